/* File: hw/stmon_top.sv */
// Top level of the system timeout monitor: configuration, response and reset pulse.
`timescale 1ns/1ps

module stmon_top (
    // Clock and reset.
    input  wire logic                              clk_i,
    input  wire logic                              nrst_i,
    // Configuration from software-controlled logic on the same clock.
    input  wire logic                              enable_i,
    input  wire logic                              mode_i,
    input  wire logic [stmon_pkg::RANGE_W-1:0]     range_sel_i,
    input  wire logic [stmon_pkg::PULSE_W-1:0]     pulse_sel_i,
    // Service strobes, one cycle each.
    input  wire logic                              restart_i,
    input  wire logic                              irq_clear_i,
    // Outputs to reset logic and interrupt controller.
    output logic                                   sys_rst_o,
    output logic                                   irq_o,
    // Observation.
    output logic [stmon_pkg::CNT_W-1:0]            count_o
);

    // ========================================================================
    // Helper functions
    // ========================================================================
    // Starting count for a range select: a mask of ones, 8 to 23 bits wide.
    function automatic logic [stmon_pkg::CNT_W-1:0] range_start(
        input logic [stmon_pkg::RANGE_W-1:0] sel
    );
        logic [5:0] shift;
        shift = 6'(stmon_pkg::RANGE_BASE_SHIFT) + 6'(sel);
        return (stmon_pkg::CNT_ONE << shift) - stmon_pkg::CNT_ONE;
    endfunction

    // Last pulse counter value for a pulse select, i.e. length minus one.
    function automatic logic [stmon_pkg::PCNT_W-1:0] pulse_last(
        input logic [stmon_pkg::PULSE_W-1:0] sel
    );
        logic [3:0] shift;
        shift = 4'(stmon_pkg::PULSE_BASE_SHIFT) + 4'(sel);
        return (stmon_pkg::PCNT_ONE << shift) - stmon_pkg::PCNT_ONE;
    endfunction

    // ========================================================================
    // Reset release
    // ========================================================================
    // The pin reset is asserted asynchronously but released through two
    // flip-flops so that no register leaves reset on a metastable edge.
    logic [1:0] rst_sync; // Release shift register.
    logic       rst_n;    // Synchronised active-low reset.

    // Release synchroniser; only the second stage is used as the reset.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ========================================================================
    // Countdown counter
    // ========================================================================
    stmon_cnt_if cnt_if ();

    stmon_counter u_counter (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .cnt_if  (cnt_if)
    );

    // ========================================================================
    // Response sequencer state
    // ========================================================================
    stmon_pkg::stmon_state_t       state;        // Present response state.
    stmon_pkg::stmon_state_t       next_state;   // State for the next edge.
    logic [stmon_pkg::PCNT_W-1:0]  pulse_cnt;    // Cycles of reset pulse so far.
    logic [stmon_pkg::PCNT_W-1:0]  next_pulse_cnt;
    logic                          irq;          // Sticky interrupt flag.
    logic                          next_irq;
    logic                          sys_rst;      // Registered system reset.
    logic                          next_sys_rst;
    logic                          was_enabled;  // Enable seen last cycle.
    logic                          next_was_enabled;

    // Counter control: the range feeds the starting count, and a restart or
    // a fresh enable reloads it. Counting pauses while the reset pulse runs,
    // so the next period begins cleanly after the pulse.
    always_comb begin
        cnt_if.start_value = range_start(range_sel_i);
        cnt_if.load        = restart_i || (enable_i && !was_enabled)
                             || (state == stmon_pkg::STMON_ST_RESET);
        cnt_if.run         = enable_i && (state != stmon_pkg::STMON_ST_RESET);
    end

    // Next-state logic of the response sequencer.
    always_comb begin
        next_state       = state;
        next_pulse_cnt   = pulse_cnt;
        next_irq         = irq;
        next_sys_rst     = sys_rst;
        next_was_enabled = enable_i;
        case (state)
            stmon_pkg::STMON_ST_COUNT: begin
                // A stale interrupt clear here changes nothing.
                if (cnt_if.timeout) begin
                    if (mode_i == stmon_pkg::STMON_MODE_DIRECT) begin
                        // No warning in direct mode: reset straight away.
                        next_state     = stmon_pkg::STMON_ST_RESET;
                        next_sys_rst   = 1'b1;
                        next_pulse_cnt = stmon_pkg::PCNT_RST;
                    end else begin
                        next_state = stmon_pkg::STMON_ST_WARNED;
                        next_irq   = 1'b1;
                    end
                end
            end
            stmon_pkg::STMON_ST_WARNED: begin
                if (cnt_if.timeout && irq) begin
                    // Still uncleared at the second timeout: escalate.
                    next_state     = stmon_pkg::STMON_ST_RESET;
                    next_sys_rst   = 1'b1;
                    next_pulse_cnt = stmon_pkg::PCNT_RST;
                end else if (cnt_if.timeout) begin
                    // Cleared in time: this timeout is a fresh first warning.
                    // A clear in this same cycle loses to the new event.
                    next_irq = 1'b1;
                end else if (irq_clear_i) begin
                    next_irq   = 1'b0;
                    next_state = stmon_pkg::STMON_ST_COUNT;
                end
                if (!enable_i) begin
                    // Disabling abandons the warning.
                    next_state = stmon_pkg::STMON_ST_COUNT;
                    next_irq   = 1'b0;
                end
            end
            stmon_pkg::STMON_ST_RESET: begin
                // Hold the reset for the selected number of cycles, then
                // drop it together with the interrupt it answered.
                if (pulse_cnt >= pulse_last(pulse_sel_i)) begin
                    next_state   = stmon_pkg::STMON_ST_COUNT;
                    next_sys_rst = 1'b0;
                    next_irq     = 1'b0;
                end else begin
                    next_pulse_cnt = pulse_cnt + stmon_pkg::PCNT_ONE;
                end
            end
            default: begin
                next_state   = stmon_pkg::STMON_ST_COUNT;
                next_sys_rst = 1'b0;
                next_irq     = 1'b0;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state       <= stmon_pkg::STMON_ST_COUNT;
            pulse_cnt   <= stmon_pkg::PCNT_RST;
            irq         <= 1'b0;
            sys_rst     <= 1'b0;
            was_enabled <= 1'b0;
        end else begin
            state       <= next_state;
            pulse_cnt   <= next_pulse_cnt;
            irq         <= next_irq;
            sys_rst     <= next_sys_rst;
            was_enabled <= next_was_enabled;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // Each output is a flip-flop: the reset and interrupt come from the
    // sequencer registers and the count from the counter register.
    assign sys_rst_o = sys_rst;
    assign irq_o     = irq;
    assign count_o   = cnt_if.count;

endmodule

/* File: hw/stmon_pkg.sv */
// Shared constants and types for the system timeout monitor.
package stmon_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int unsigned CNT_W   = 32; // Width of the countdown counter.
    localparam int unsigned RANGE_W = 4;  // Width of the timeout range select.
    localparam int unsigned PULSE_W = 3;  // Width of the reset pulse select.
    localparam int unsigned PCNT_W  = 9;  // Width of the reset pulse counter.

    // ========================================================================
    // Range and pulse encodings
    // ========================================================================
    // Range n starts the countdown at 2^(RANGE_BASE_SHIFT + n) - 1.
    // A short base keeps the shortest period brief enough to exercise every
    // response path; the longest range still spans millions of cycles.
    localparam int unsigned RANGE_BASE_SHIFT = 8;
    // Pulse select n holds the reset for 2^(PULSE_BASE_SHIFT + n) cycles.
    localparam int unsigned PULSE_BASE_SHIFT = 1;

    // ========================================================================
    // Reset values and unit steps
    // ========================================================================
    localparam logic [CNT_W-1:0]  CNT_RST  = 32'h0000_0000; // Counter after reset.
    localparam logic [CNT_W-1:0]  CNT_ONE  = 32'h0000_0001; // Unit step and shift seed.
    localparam logic [PCNT_W-1:0] PCNT_RST = 9'h000;        // Pulse counter after reset.
    localparam logic [PCNT_W-1:0] PCNT_ONE = 9'h001;        // Pulse counter step.

    // Response modes.
    typedef enum logic {
        STMON_MODE_DIRECT    = 1'b0,
        STMON_MODE_TWO_STAGE = 1'b1
    } stmon_mode_t;

    // Response sequencer states.
    typedef enum logic [1:0] {
        STMON_ST_COUNT,
        STMON_ST_WARNED,
        STMON_ST_RESET
    } stmon_state_t;

endpackage

/* File: hw/stmon_cnt_if.sv */
// Interface between the response sequencer and the countdown counter.
`timescale 1ns/1ps
interface stmon_cnt_if;
    logic                           load;        // Reload the starting value now.
    logic                           run;         // Count down while high.
    logic [stmon_pkg::CNT_W-1:0]    start_value; // Starting value of the countdown.
    logic [stmon_pkg::CNT_W-1:0]    count;       // Present counter value.
    logic                           timeout;     // One-cycle pulse after zero is reached.

    modport ctl (output load, output run, output start_value, input count, input timeout);
    modport cnt (input load, input run, input start_value, output count, output timeout);
endinterface

/* File: hw/stmon_counter.sv */
// Countdown counter of the system timeout monitor.
`timescale 1ns/1ps
module stmon_counter (
    // Clock and synchronised reset.
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    // Link to the response sequencer.
    stmon_cnt_if.cnt    cnt_if
);

    // ========================================================================
    // Counter state
    // ========================================================================
    logic [stmon_pkg::CNT_W-1:0] count;        // Present count.
    logic [stmon_pkg::CNT_W-1:0] next_count;   // Count for the next edge.
    logic                        timeout;      // Registered timeout pulse.
    logic                        next_timeout; // Timeout for the next edge.

    // Next-state logic: a load wins over counting, so a restart in the
    // very cycle of expiry prevents the timeout.
    always_comb begin
        next_count   = count;
        next_timeout = 1'b0;
        if (cnt_if.load) begin
            next_count = cnt_if.start_value;
        end else if (cnt_if.run) begin
            if (count == stmon_pkg::CNT_RST) begin
                // Zero reached: flag a timeout and start the next period.
                next_timeout = 1'b1;
                next_count   = cnt_if.start_value;
            end else begin
                next_count = count - stmon_pkg::CNT_ONE;
            end
        end
    end

    // Registers run on the bus clock itself; there is no other count clock.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count   <= stmon_pkg::CNT_RST;
            timeout <= 1'b0;
        end else begin
            count   <= next_count;
            timeout <= next_timeout;
        end
    end

    assign cnt_if.count   = count;
    assign cnt_if.timeout = timeout;

endmodule

/* File: test/stmon_sva.sv */
// Assertion checker for the system timeout monitor top level.
`timescale 1ns/1ps
module stmon_sva (
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        nrst_i,
    // Configuration and service inputs.
    input wire logic        enable_i,
    input wire logic        mode_i,
    input wire logic [3:0]  range_sel_i,
    input wire logic [2:0]  pulse_sel_i,
    input wire logic        restart_i,
    input wire logic        irq_clear_i,
    // Outputs under watch.
    input wire logic        sys_rst_o,
    input wire logic        irq_o,
    input wire logic [31:0] count_o
);
    logic [8:0] hi_cnt; // Samples for which the reset output has been high.

    // Count reset pulse cycles; a low output clears it, so each pulse is measured alone.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_cnt <= 9'h000;
        end else begin
            hi_cnt <= sys_rst_o ? hi_cnt + 9'h001 : 9'h000;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_rst_after_zero: assert property ($rose(sys_rst_o) |-> $past(count_o, 2) == 32'h0000_0000)
        else $error("reset rose without the counter at zero");
    a_direct_no_irq: assert property (!mode_i && !$past(mode_i) && !$past(mode_i, 2) |-> !$rose(irq_o))
        else $error("interrupt raised in direct mode");
    a_count_steps: assert property ($past(enable_i) && $past(enable_i, 2) && !$past(restart_i)
        && !$past(sys_rst_o) && !sys_rst_o && $past(count_o) != 32'h0000_0000
        |-> count_o == $past(count_o) - 32'h0000_0001)
        else $error("counter did not step down by one");
    a_restart_loads: assert property ($past(restart_i) && $past(enable_i) && !$past(sys_rst_o) && !sys_rst_o
        |-> count_o == (stmon_pkg::CNT_ONE << (stmon_pkg::RANGE_BASE_SHIFT + $past(range_sel_i)))
        - stmon_pkg::CNT_ONE)
        else $error("restart did not load the range start value");
    a_pulse_len: assert property ($fell(sys_rst_o)
        |-> hi_cnt == (stmon_pkg::PCNT_ONE << (stmon_pkg::PULSE_BASE_SHIFT + pulse_sel_i)))
        else $error("reset pulse length wrong");
    a_warn_first: assert property ($rose(irq_o) |-> mode_i && !sys_rst_o && $past(count_o, 2) == 32'h0000_0000)
        else $error("interrupt rose without a timeout");
    a_clear_irq: assert property (irq_o && irq_clear_i && !sys_rst_o && count_o != 32'h0000_0000
        && $past(count_o) != 32'h0000_0000 |=> !irq_o)
        else $error("interrupt clear ignored");
    a_second_reset: assert property (mode_i && $past(mode_i, 3) && $rose(sys_rst_o) |-> irq_o)
        else $error("two-stage reset without a pending interrupt");
endmodule

bind stmon_top stmon_sva u_sva (.clk_i(clk_i), .nrst_i(nrst_i), .enable_i(enable_i),
    .mode_i(mode_i), .range_sel_i(range_sel_i), .pulse_sel_i(pulse_sel_i),
    .restart_i(restart_i), .irq_clear_i(irq_clear_i), .sys_rst_o(sys_rst_o),
    .irq_o(irq_o), .count_o(count_o));

/* File: test/stmon_sys_model.sv */
// Model of the reset logic and interrupt controller at the monitor's outputs.
`timescale 1ns/1ps
module stmon_sys_model (
    // Clock and monitor outputs.
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic irq_i,
    // Service strobe and measured pulse length.
    output logic      irq_clear_o,
    output int        pulse_len_o
);
    int run_len; // High samples in the present reset pulse.

    initial irq_clear_o = 1'b0;
    initial pulse_len_o = 0;
    initial run_len = 0;

    // Keep the last pulse length visible after the pulse ends.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            pulse_len_o <= run_len;
            run_len <= 0;
        end
    end

    // Service routine: one-cycle clear, only for a pending interrupt.
    task automatic service();
        if (irq_i === 1'b1) begin
            irq_clear_o = 1'b1;
            @(negedge clk_i);
            irq_clear_o = 1'b0;
        end
    endtask
endmodule

/* File: test/testbench.sv */
// Self-checking testbench for the system timeout monitor.
`timescale 1ns/1ps
module testbench;
    // ========================================================================
    // Signals
    // ========================================================================
    logic        clk_i;
    logic        nrst_i;
    logic        enable_i;
    logic        mode_i;
    logic [3:0]  range_sel_i;
    logic [2:0]  pulse_sel_i;
    logic        restart_i;
    logic        irq_clear_i;
    logic        sys_rst_o;
    logic        irq_o;
    logic [31:0] count_o;
    int          pulse_len;
    int          miscompares;
    int          cmp_count;

    // Cycles from a load to the timeout pulse at range 0.
    localparam int PERIOD = 1 << stmon_pkg::RANGE_BASE_SHIFT;

    stmon_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .enable_i(enable_i), .mode_i(mode_i),
        .range_sel_i(range_sel_i), .pulse_sel_i(pulse_sel_i), .restart_i(restart_i),
        .irq_clear_i(irq_clear_i), .sys_rst_o(sys_rst_o), .irq_o(irq_o), .count_o(count_o));
    stmon_sys_model sys_model (.clk_i(clk_i), .sys_rst_i(sys_rst_o), .irq_i(irq_o),
        .irq_clear_o(irq_clear_i), .pulse_len_o(pulse_len));

    // ========================================================================
    // Helpers
    // ========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Count falling edges until the chosen output (0 reset, 1 irq) shows the level.
    task automatic wait_lvl(input int sel, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (((sel == 0) ? sys_rst_o : irq_o) !== lvl && n < 4 * PERIOD);
    endtask

    task automatic do_restart();
        restart_i = 1'b1;
        @(negedge clk_i);
        restart_i = 1'b0;
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    // Every range loads its own start value, then steps down.
    task automatic t_ranges();
        logic [31:0] start;
        enable_i = 1'b1;
        @(negedge clk_i);
        for (int r = 0; r < 16; r++) begin
            range_sel_i = r[3:0];
            start = (32'h0000_0001 << (stmon_pkg::RANGE_BASE_SHIFT + r)) - 32'h0000_0001;
            do_restart();
            chk(count_o, start, "start value");
            @(negedge clk_i);
            chk(count_o, start - 32'h0000_0001, "step");
        end
    endtask

    // Direct mode resets at once, with the shortest pulse.
    task automatic t_direct();
        int n;
        mode_i = 1'b0;
        pulse_sel_i = 3'h0;
        range_sel_i = 4'h0;
        do_restart();
        wait_lvl(0, 1'b1, n);
        chk(n, PERIOD + 1, "direct delay");
        chk({31'h0, irq_o}, 32'h0, "direct irq");
        wait_lvl(0, 1'b0, n);
        @(negedge clk_i);
        chk(pulse_len, 2, "short pulse");
    endtask

    // Two-stage: warn, clear, warn again, then reset when left uncleared.
    task automatic t_two_stage();
        int n;
        mode_i = 1'b1;
        pulse_sel_i = 3'h7;
        do_restart();
        wait_lvl(1, 1'b1, n);
        chk(n, PERIOD + 1, "first warning");
        chk({31'h0, sys_rst_o}, 32'h0, "early reset");
        sys_model.service();
        chk({31'h0, irq_o}, 32'h0, "irq clear");
        wait_lvl(1, 1'b1, n);
        chk(n + 1, PERIOD, "new warning");
        wait_lvl(0, 1'b1, n);
        chk(n, PERIOD, "second timeout");
        chk({31'h0, irq_o}, 32'h1, "irq held");
        wait_lvl(0, 1'b0, n);
        @(negedge clk_i);
        chk(pulse_len, 256, "long pulse");
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        miscompares = 0;
        cmp_count = 0;
        nrst_i = 1'b0;
        enable_i = 1'b0;
        mode_i = 1'b0;
        range_sel_i = 4'h0;
        pulse_sel_i = 3'h0;
        restart_i = 1'b0;
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_ranges();
        t_direct();
        t_two_stage();
        finish_test();
    end

    // Watchdog: the tests need about 1330 cycles; allow 10000.
    initial begin
        #400_000;
        miscompares++;
        $display("BAD %0t run did not finish", $time);
        finish_test();
    end
endmodule
